// *** src/ksi_bus_if.sv ***
// Interface for the two-wire bus between the slave port and the master end.
// Assumes ideal pull-ups, modelled here; open-drain levels resolved from enables.
`timescale 1ns/1ns
interface ksi_bus_if;
    logic scl_oe;     // Master pulls clock low
    logic sda_m_oe;   // Master pulls data low
    logic sda_s_oe;   // Slave pulls data low
    logic scl;        // Resolved clock level
    logic sda;        // Resolved data level
    // Wired-AND of all pull-downs
    assign scl = ~scl_oe;
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport slave (input scl, input sda, output sda_s_oe);
    modport master (input scl, input sda, output scl_oe, output sda_m_oe);
endinterface : ksi_bus_if

// *** src/ksi_master.sv ***
// Bus master end: runs one byte-oriented transfer per user command.
// Assumes the slave on the same interface; drives clock from a divider.
`timescale 1ns/1ns
module ksi_master #(
    parameter int HALF_CYC = ksi_pkg::MST_HALF_CYC
) (
    input wire logic clk_sys_i,        // System clock
    input wire logic arst_n_i,         // Async reset, active low
    ksi_bus_if.master bus,             // Two-wire bus
    input wire logic start_i,          // Pulse: send START+address
    input wire logic [6:0] addr_i,     // Slave address
    input wire logic rw_i,             // 1 read
    input wire logic byte_i,           // Pulse: transfer one byte
    input wire logic [7:0] wdata_i,    // Byte to write
    input wire logic last_i,           // Read: nack this byte
    input wire logic stop_i,           // Pulse: send STOP
    output logic busy_o,               // Operation running
    output logic done_o,               // Pulse at operation end
    output logic ack_o,                // Acknowledge seen
    output logic [7:0] rdata_o         // Byte read
);
    // Phases shorter than the slave's synchroniser delay would be missed
    if (HALF_CYC < 2) begin : g_bad_half
        $error("HALF_CYC too small");
    end
    typedef enum logic [3:0] {
        KSM_IDLE = 4'b0001, KSM_START = 4'b0010, KSM_BITS = 4'b0100, KSM_STOP = 4'b1000
    } ksm_state_t;
    ksm_state_t state;
    logic [15:0] div;
    logic tick;
    logic [1:0] sda_sy;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [8:0] sh;
    logic rd;
    assign tick = (div == 16'(HALF_CYC - 1));
    //////////////////////////////////////////////////////////////////////////
    // Quarter-bit divider
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div <= 16'h0000;
            sda_sy <= 2'h3;
        end else begin
            div <= tick ? 16'h0000 : div + 16'h0001;
            sda_sy <= {sda_sy[0], bus.sda};
        end
    end
    assign busy_o = (state != KSM_IDLE);
    // Sequencer; phase 0 low, 1 rise, 2 high/sample, 3 fall
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= KSM_IDLE;
            bus.scl_oe <= 1'b0;
            bus.sda_m_oe <= 1'b0;
            bitn <= 4'h0;
            ph <= 2'h0;
            sh <= 9'h000;
            rd <= 1'b0;
            done_o <= 1'b0;
            ack_o <= 1'b0;
            rdata_o <= 8'h00;
        end else begin
            done_o <= 1'b0;
            case (state)
                KSM_IDLE: begin
                    ph <= 2'h0;
                    bitn <= 4'h0;
                    if (start_i) begin
                        state <= KSM_START;
                        sh <= {addr_i, rw_i, 1'b1};
                        rd <= 1'b0;
                    end else if (byte_i) begin
                        state <= KSM_BITS;
                        sh <= rd ? {8'hFF, last_i} : {wdata_i, 1'b1};
                    end else if (stop_i) begin
                        state <= KSM_STOP;
                    end
                end
                KSM_START: if (tick) begin
                    ph <= ph + 2'h1;
                    case (ph)
                        2'h0: begin
                            bus.sda_m_oe <= 1'b0;
                            bus.scl_oe <= 1'b0;
                        end
                        2'h1: bus.sda_m_oe <= 1'b1;
                        2'h2: bus.scl_oe <= 1'b1;
                        default: begin
                            state <= KSM_BITS;
                            rd <= sh[1];  // Direction captured with the address
                        end
                    endcase
                end
                KSM_BITS: if (tick) begin
                    ph <= ph + 2'h1;
                    case (ph)
                        2'h0: bus.sda_m_oe <= ~sh[8];
                        2'h1: bus.scl_oe <= 1'b0;
                        2'h2: begin
                            sh <= {sh[7:0], sda_sy[1]};
                        end
                        default: begin
                            bus.scl_oe <= 1'b1;
                            bitn <= bitn + 4'h1;
                            if (bitn == 4'h8) begin
                                bus.sda_m_oe <= 1'b0;
                                ack_o <= ~sh[0];
                                rdata_o <= sh[8:1];
                                done_o <= 1'b1;
                                state <= KSM_IDLE;
                            end
                        end
                    endcase
                end
                KSM_STOP: if (tick) begin
                    ph <= ph + 2'h1;
                    case (ph)
                        2'h0: bus.sda_m_oe <= 1'b1;
                        2'h1: bus.scl_oe <= 1'b0;
                        2'h2: bus.sda_m_oe <= 1'b0;
                        default: begin
                            done_o <= 1'b1;
                            state <= KSM_IDLE;
                        end
                    endcase
                end
                default: state <= KSM_IDLE;
            endcase
        end
    end
endmodule : ksi_master

// *** src/ksi_pkg.sv ***
// Package for the keypad/sounder two-wire slave port and its master end.
// Assumes one system clock of 50 MHz shared by both ends.
package ksi_pkg;
    // Fixed upper address bits shared by both slave addresses
    localparam logic [3:0] ADDR_FIXED = 4'h7;
    // Address-select strap codes
    localparam logic [1:0] SEL_GND = 2'h0;
    localparam logic [1:0] SEL_VDD = 2'h1;
    localparam logic [1:0] SEL_SDA = 2'h2;
    localparam logic [1:0] SEL_SCL = 2'h3;
    // Target controller in the lowest address bit
    localparam logic TGT_KEYSCAN = 1'b0;
    localparam logic TGT_SOUNDER = 1'b1;
    // Key-scan register pointers
    localparam logic [7:0] REG_KEY_FIFO = 8'h00;
    localparam logic [7:0] REG_DEBOUNCE = 8'h01;
    localparam logic [7:0] REG_AUTOREPEAT = 8'h02;
    localparam logic [7:0] REG_INTERRUPT = 8'h03;
    localparam logic [7:0] REG_CONFIG = 8'h04;
    localparam logic [7:0] REG_PORTS = 8'h05;
    localparam logic [7:0] REG_KEY_SOUND = 8'h06;
    localparam logic [7:0] REG_ALERT_SOUND = 8'h07;
    localparam logic [7:0] PTR_RESET = 8'h00;
    // Configuration register timeout-enable bit and its reset value
    localparam int CFG_TIMEOUT_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h01;
    // Key code layout: column * 8 + row
    localparam int KEY_ROWS = 8;
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int TIMEOUT_MS = 20;
    localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int MST_HALF_CYC = 4;

    // Key number from column and row indices
    function automatic logic [5:0] ksi_key_code(input logic [2:0] col, input logic [2:0] row);
        ksi_key_code = {col, row};
    endfunction : ksi_key_code

    // Pointer step: 0 holds, 7 wraps to 0, others advance
    function automatic logic [7:0] ksi_next_ptr(input logic [7:0] ptr);
        if (ptr == REG_KEY_FIFO) begin
            ksi_next_ptr = REG_KEY_FIFO;
        end else if (ptr == REG_ALERT_SOUND) begin
            ksi_next_ptr = REG_KEY_FIFO;
        end else begin
            ksi_next_ptr = ptr + 8'h01;
        end
    endfunction : ksi_next_ptr
endpackage : ksi_pkg

// *** src/ksi_slave.sv ***
// Two-wire slave port of the keypad/sounder peripheral.
// Assumes an external master on the bus interface; registers live behind user ports.
`timescale 1ns/1ns
module ksi_slave #(
    parameter bit SMALL_VARIANT = 1'b0,
    parameter int TIMEOUT_CYCLES = ksi_pkg::TIMEOUT_CYC
) (
    input wire logic clk_sys_i,               // System clock
    input wire logic arst_n_i,                // Async reset, active low
    ksi_bus_if.slave bus,                     // Two-wire bus
    input wire logic [1:0] address_select_i,  // Strap level code of select pin
    output logic ks_wr_o,                     // Key-scan register write pulse
    output logic [2:0] ks_sel_o,              // Register index 0..7
    output logic [7:0] ks_wdata_o,            // Write data
    output logic ks_rd_o,                     // Read fetch pulse
    input wire logic [7:0] ks_rdata_i,        // Read data at ks_sel_o
    output logic snd_wr_o,                    // Sounder command pulse
    output logic [7:0] snd_wdata_o,           // Sounder command byte
    input wire logic [7:0] snd_status_i,      // Sounder status byte
    output logic timeout_o,                   // Abort pulse
    output logic [7:0] ptr_o                  // Current pointer
);
    // Watchdog needs room to count before it may fire
    if (TIMEOUT_CYCLES < 2) begin : g_bad_timeout
        $error("TIMEOUT_CYCLES too small");
    end

    typedef enum logic [5:0] {
        KSI_IDLE = 6'b00_0001,
        KSI_ADDR = 6'b00_0010,
        KSI_RX = 6'b00_0100,
        KSI_TX = 6'b00_1000,
        KSI_ACK = 6'b01_0000,
        KSI_MACK = 6'b10_0000
    } ksi_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers, then one history stage for edge finding
    logic [1:0] scl_sy, sda_sy;
    logic scl_q, sda_q;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_sy <= 2'h3;
            sda_sy <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sy <= {scl_sy[0], bus.scl};
            sda_sy <= {sda_sy[0], bus.sda};
            scl_q <= scl_sy[1];
            sda_q <= sda_sy[1];
        end
    end
    logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
    assign scl_s = scl_sy[1];
    assign sda_s = sda_sy[1];
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_det = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // Own address: fixed nibble, strap bits, target in lowest bit
    logic [1:0] sel_eff;
    assign sel_eff = SMALL_VARIANT ? ksi_pkg::SEL_GND : address_select_i;
    function automatic logic addr_match(input logic [6:0] a, input logic [1:0] sel);
        addr_match = (a[6:3] == ksi_pkg::ADDR_FIXED) && (a[2:1] == sel);
    endfunction : addr_match

    ////////////////////////////////////////////////////////////////////////////
    // Byte engine
    ksi_state_t state;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic rd_mode, tgt, first_byte, nack_seen, cfg_to_en, abort;
    logic [7:0] ptr;
    logic [31:0] stall_cnt;

    // Stall watchdog between adjacent clock edges while a transfer is open
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stall_cnt <= 32'h0000_0000;
        end else if (state == KSI_IDLE || scl_rise || scl_fall) begin
            stall_cnt <= 32'h0000_0000;
        end else if (stall_cnt < 32'(TIMEOUT_CYCLES)) begin
            stall_cnt <= stall_cnt + 32'h0000_0001;
        end
    end
    assign abort = cfg_to_en && (state != KSI_IDLE) &&
                   (stall_cnt >= 32'(TIMEOUT_CYCLES));

    // Bus state machine; START wins over everything, abort next
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= KSI_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            rd_mode <= 1'b0;
            tgt <= 1'b0;
            first_byte <= 1'b0;
            nack_seen <= 1'b0;
        end else if (start_det) begin
            state <= KSI_ADDR;
            bitcnt <= 4'h0;
        end else if (abort || stop_det) begin
            state <= KSI_IDLE;
        end else begin
            case (state)
                KSI_ADDR, KSI_RX: begin
                    if (scl_rise) begin
                        shreg <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        bitcnt <= 4'h0;
                        if (state == KSI_ADDR) begin
                            if (addr_match(shreg[7:1], sel_eff)) begin
                                rd_mode <= shreg[0];
                                tgt <= shreg[1];
                                first_byte <= 1'b1;
                                state <= KSI_ACK;
                            end else begin
                                state <= KSI_IDLE;
                            end
                        end else begin
                            state <= KSI_ACK;
                            first_byte <= 1'b0;       // Later bytes are data
                        end
                    end
                end
                KSI_ACK: begin
                    if (scl_fall) begin
                        state <= rd_mode ? KSI_TX : KSI_RX;
                        if (rd_mode) begin
                            shreg <= (tgt == ksi_pkg::TGT_SOUNDER) ? snd_status_i : ks_rdata_i;
                        end
                    end
                end
                KSI_TX: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h7) begin
                            bitcnt <= 4'h0;
                            state <= KSI_MACK;
                        end else begin
                            bitcnt <= bitcnt + 4'h1;
                            shreg <= {shreg[6:0], 1'b0};
                        end
                    end
                end
                KSI_MACK: begin
                    if (scl_rise) begin
                        nack_seen <= sda_s;
                    end else if (scl_fall) begin
                        state <= nack_seen ? KSI_IDLE : KSI_TX;
                        shreg <= (tgt == ksi_pkg::TGT_SOUNDER) ? snd_status_i : ks_rdata_i;
                    end
                end
                default: state <= KSI_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer, register strobes and timeout-enable copy
    logic rx_done;
    assign rx_done = (state == KSI_RX) && scl_fall && (bitcnt == 4'h8);
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr <= ksi_pkg::PTR_RESET;
            ks_wr_o <= 1'b0;
            ks_wdata_o <= 8'h00;
            snd_wr_o <= 1'b0;
            snd_wdata_o <= 8'h00;
            cfg_to_en <= ksi_pkg::CFG_RESET[ksi_pkg::CFG_TIMEOUT_BIT];
        end else begin
            ks_wr_o <= 1'b0;
            snd_wr_o <= 1'b0;
            if (rx_done && tgt == ksi_pkg::TGT_SOUNDER) begin
                snd_wr_o <= 1'b1;
                snd_wdata_o <= shreg;
            end else if (rx_done && first_byte) begin
                ptr <= shreg;
            end else if (rx_done) begin
                ks_wr_o <= 1'b1;
                ks_wdata_o <= shreg;
                if (ptr == ksi_pkg::REG_CONFIG) begin
                    cfg_to_en <= shreg[ksi_pkg::CFG_TIMEOUT_BIT];
                end
            end else if (ks_wr_o || ks_rd_o) begin
                // Step after the strobe, so ks_sel_o names the register accessed
                ptr <= ksi_pkg::ksi_next_ptr(ptr);
            end
        end
    end

    // Fetch strobe marks when read data is sampled
    assign ks_rd_o = (state == KSI_ACK || state == KSI_MACK) && scl_fall && rd_mode &&
                     tgt == ksi_pkg::TGT_KEYSCAN && !(state == KSI_MACK && nack_seen);
    assign ks_sel_o = ptr[2:0];
    assign ptr_o = ptr;
    assign timeout_o = abort;

    // Open-drain data drive: ack low, or read data zeros
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus.sda_s_oe <= 1'b0;
        end else if (start_det || abort || stop_det) begin
            bus.sda_s_oe <= 1'b0;
        end else begin
            bus.sda_s_oe <= (state == KSI_ACK) ||
                            (state == KSI_TX && !shreg[7]);
        end
    end
endmodule : ksi_slave

// *** test/ksi_bus_sva.sv ***
// Checker for the two-wire bus joining the master end and the slave port.
// Assumes one clock domain; sees only the interface's enables and levels.
`timescale 1ns/1ns
module ksi_bus_sva #(
    parameter int TIMEOUT_CYCLES = 200
) (
    input wire logic clk_sys_i, // System clock
    input wire logic arst_n_i,  // Async reset, active low
    input wire logic scl_oe,    // Master clock pull
    input wire logic sda_m_oe,  // Master data pull
    input wire logic sda_s_oe,  // Slave data pull
    input wire logic scl,       // Clock level
    input wire logic sda        // Data level
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    logic scl_q, sda_q, first_byte, start_c;
    logic [3:0] bit_cnt;
    logic [7:0] sh;
    int stall_cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // START seen on the raw lines, no synchroniser delay here
    assign start_c = scl & scl_q & sda_q & ~sda;
    // Line history; idle bus is high after reset
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // Bit position and shifted address since START
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            first_byte <= 1'b0;
            bit_cnt <= 4'h0;
            sh <= 8'h00;
        end else if (start_c) begin
            first_byte <= 1'b1;
            bit_cnt <= 4'h0;
        end else if (scl && !scl_q) begin
            sh <= {sh[6:0], sda};
            bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
            if (bit_cnt == 4'h8) begin
                first_byte <= 1'b0;
            end
        end
    end
    // Cycles since the last clock edge; saturates so it never wraps
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stall_cnt <= 0;
        end else if (scl != scl_q) begin
            stall_cnt <= 0;
        end else if (stall_cnt < TIMEOUT_CYCLES + 16) begin
            stall_cnt <= stall_cnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence stop_s;
        scl && $past(scl) && !$past(sda) && sda;
    endsequence
    sequence rise_s;
        $rose(scl);
    endsequence
    a_slave_pull_low: assert property (
        $rose(sda_s_oe) |-> !scl)
        else $error("Slave pulled data while clock high");
    a_slave_stable_high: assert property (
        scl && $past(scl) |-> $stable(sda_s_oe))
        else $error("Slave data changed while clock high");
    a_clock_high_min: assert property (
        rise_s |-> scl [*4])
        else $error("Clock high phase too short");
    a_clock_low_min: assert property (
        $fell(scl) |-> !scl [*4])
        else $error("Clock low phase too short");
    a_timeout_release: assert property (
        stall_cnt > TIMEOUT_CYCLES + 8 |-> !sda_s_oe)
        else $error("Slave held data through a clock stall");
    a_stop_quiet: assert property (
        stop_s |=> !sda_s_oe [*8])
        else $error("Slave drove data after STOP");
    a_addr_quiet: assert property (
        first_byte && bit_cnt < 4'h8 |-> !sda_s_oe)
        else $error("Slave drove data during address bits");
    a_foreign_no_ack: assert property (
        first_byte && bit_cnt == 4'h8 && sh[7:4] != ksi_pkg::ADDR_FIXED |-> !sda_s_oe)
        else $error("Slave answered a foreign address");
endmodule : ksi_bus_sva

// *** test/tb_keypad_sounder_i2c_slave_port.sv ***
// Bench joining master end and slave port over the bus interface.
// Assumes the master end obeys its hand-over contract; registers are modelled.
`timescale 1ns/1ns
module tb_keypad_sounder_i2c_slave_port;
    localparam int TMO = 200;
    typedef struct packed {
        logic [1:0] sel;
        logic [6:0] addr;
        logic [7:0] ptr;
        logic [7:0] data;
        logic ack;
    } ksi_row_t;
    logic clk_sys_i = 1'b0, arst_n_i = 1'b0, ks_wr, ks_rd, snd_wr, tmo;
    logic m_start, m_rw, m_byte, m_last, m_stop, m_busy, m_done, m_ack;
    logic [6:0] m_addr;
    logic [7:0] m_wdata, m_rdata, ks_wdata, ks_rdata, snd_wdata, snd_status, ptr;
    logic [7:0] wr_dat, snd_dat, exp_ptr;
    logic [2:0] ks_sel, wr_sel;
    logic [1:0] strap;
    int num_errors = 0, cmp_count = 0, wr_cnt = 0, wc;
    bit tmo_seen;
    ksi_row_t rows [10] = '{'{2'h0, 7'h38, 8'h01, 8'h11, 1'b1},
        '{2'h1, 7'h3A, 8'h02, 8'h22, 1'b1}, '{2'h2, 7'h3C, 8'h06, 8'h33, 1'b1},
        '{2'h3, 7'h3E, 8'h07, 8'h44, 1'b1}, '{2'h0, 7'h38, 8'h00, 8'h77, 1'b1},
        '{2'h3, 7'h3F, 8'h05, 8'h55, 1'b1}, '{2'h0, 7'h39, 8'h03, 8'h66, 1'b1},
        '{2'h2, 7'h3E, 8'h00, 8'h00, 1'b0}, '{2'h1, 7'h38, 8'h00, 8'h00, 1'b0},
        '{2'h0, 7'h78, 8'h00, 8'h00, 1'b0}};
    ksi_bus_if bus ();
    ////////////////////////////////////////////////////////////////////////////////
    ksi_slave #(.SMALL_VARIANT(1'b0), .TIMEOUT_CYCLES(TMO)) ksi_slave_inst (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus(bus), .address_select_i(strap),
        .ks_wr_o(ks_wr), .ks_sel_o(ks_sel), .ks_wdata_o(ks_wdata), .ks_rd_o(ks_rd),
        .ks_rdata_i(ks_rdata), .snd_wr_o(snd_wr), .snd_wdata_o(snd_wdata),
        .snd_status_i(snd_status), .timeout_o(tmo), .ptr_o(ptr));
    ksi_master ksi_master_inst (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .bus(bus), .start_i(m_start),
        .addr_i(m_addr), .rw_i(m_rw), .byte_i(m_byte), .wdata_i(m_wdata), .last_i(m_last),
        .stop_i(m_stop), .busy_o(m_busy), .done_o(m_done), .ack_o(m_ack), .rdata_o(m_rdata));
    ksi_bus_sva #(.TIMEOUT_CYCLES(TMO)) ksi_bus_sva_inst (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .scl_oe(bus.scl_oe),
        .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));
    ////////////////////////////////////////////////////////////////////////////////
    always #10 clk_sys_i = ~clk_sys_i;
    // Register file stand-in: bit 7 low so a read drives the data line
    assign ks_rdata = {5'h0A, ks_sel};
    // Sample pulses mid-cycle, away from the edge that updates them
    always @(negedge clk_sys_i) begin
        if (ks_wr === 1'b1) begin
            wr_cnt++;
            wr_sel = ks_sel;
            wr_dat = ks_wdata;
        end
        if (snd_wr === 1'b1) snd_dat = snd_wdata;
        if (tmo === 1'b1) tmo_seen = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One master command: 0 START+address, 1 byte, 2 STOP; waits for done
    task automatic op(input int k, input logic [7:0] d, input logic l);
        int n;
        @(posedge clk_sys_i);
        #2;
        {m_addr, m_rw} = d;
        m_wdata = d;
        m_last = l;
        m_start = (k == 0);
        m_byte = (k == 1);
        m_stop = (k == 2);
        @(posedge clk_sys_i);
        #2;
        {m_start, m_byte, m_stop} = 3'h0;
        for (n = 0; n < 4000 && m_done !== 1'b1; n++) begin
            @(posedge clk_sys_i);
            #1;
        end
        if (m_done !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED done expected 1 seen %b", m_done);
            final_report();
        end
    endtask : op
    function automatic logic [7:0] nx(input logic [7:0] p);
        nx = (p == 8'h00 || p == 8'h07) ? 8'h00 : p + 8'h01;
    endfunction : nx
    task automatic stall(input int c);
        tmo_seen = 1'b0;
        repeat (c) @(posedge clk_sys_i);
    endtask : stall
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: table of addressed writes, then hand-written cases
    initial begin
        {m_start, m_rw, m_byte, m_last, m_stop, m_addr, m_wdata} = '0;
        strap = 2'h0;
        snd_status = 8'hC3;
        exp_ptr = 8'h00;
        repeat (5) @(posedge clk_sys_i);
        #2;
        arst_n_i = 1'b1;
        foreach (rows[i]) begin
            strap = rows[i].sel;
            op(0, {rows[i].addr, 1'b0}, 1'b0);
            chk("address ack", {7'h00, rows[i].ack}, {7'h00, m_ack});
            if (rows[i].ack) begin
                op(1, rows[i].ptr, 1'b0);
                op(1, rows[i].data, 1'b0);
                chk("data ack", 8'h01, {7'h00, m_ack});
            end
            op(2, 8'h00, 1'b0);
            if (rows[i].ack && rows[i].addr[0] == ksi_pkg::TGT_KEYSCAN) begin
                exp_ptr = nx(rows[i].ptr);
                chk("write sel", rows[i].ptr, {5'h00, wr_sel});
                chk("write data", rows[i].data, wr_dat);
            end else if (rows[i].ack) begin
                chk("sound cmd", rows[i].data, snd_dat);
            end
            chk("pointer", exp_ptr, ptr);
        end
        $display("Test address table done");
        wc = wr_cnt;
        op(0, 8'h70, 1'b0);
        op(1, 8'h05, 1'b0);
        op(2, 8'h00, 1'b0);
        chk("write count", wc[7:0], wr_cnt[7:0]);
        chk("pointer only", 8'h05, ptr);
        $display("Test pointer only done");
        @(posedge clk_sys_i);
        #2;
        arst_n_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        #2;
        arst_n_i = 1'b1;
        chk("reset pointer", 8'h00, ptr);
        chk("reset timeout", 8'h00, {7'h00, tmo});
        $display("Test reset done");
        op(0, 8'h70, 1'b0);
        op(1, 8'h06, 1'b0);
        op(1, 8'hA1, 1'b0);
        op(1, 8'hA2, 1'b0);
        op(2, 8'h00, 1'b0);
        chk("burst sel", 8'h07, {5'h00, wr_sel});
        chk("burst data", 8'hA2, wr_dat);
        chk("burst wrap", 8'h00, ptr);
        $display("Test burst done");
        op(0, 8'h70, 1'b0);
        op(1, 8'h02, 1'b0);
        op(0, 8'h71, 1'b0);
        op(1, 8'h00, 1'b0);
        chk("read first", {5'h0A, 3'h2}, m_rdata);
        op(1, 8'h00, 1'b1);
        chk("read next", {5'h0A, 3'h3}, m_rdata);
        op(2, 8'h00, 1'b0);
        chk("read pointer", 8'h04, ptr);
        op(0, 8'h73, 1'b0);
        op(1, 8'h00, 1'b1);
        op(2, 8'h00, 1'b0);
        chk("sound status", 8'hC3, m_rdata);
        chk("key code", 8'h3B, {2'h0, ksi_pkg::ksi_key_code(3'h7, 3'h3)});
        $display("Test reads done");
        op(0, 8'h70, 1'b0);
        op(1, 8'h02, 1'b0);
        op(0, 8'h71, 1'b0);
        stall(TMO + 60);
        chk("timeout seen", 8'h01, {7'h00, tmo_seen});
        chk("data released", 8'h00, {7'h00, bus.sda_s_oe});
        op(1, 8'h00, 1'b1);
        chk("ignored read", 8'hFF, m_rdata);
        op(2, 8'h00, 1'b0);
        op(0, 8'h70, 1'b0);
        op(1, ksi_pkg::REG_CONFIG, 1'b0);
        op(1, 8'h00, 1'b0);
        stall(TMO + 60);
        chk("timeout off", 8'h00, {7'h00, tmo_seen});
        op(2, 8'h00, 1'b0);
        $display("Test timeout done");
        final_report();
    end
endmodule : tb_keypad_sounder_i2c_slave_port
